// file: inc/pswc_pkg.sv
// Constants and types for the power-save and wake control block
// Functional notes
// (R1) Programmed fuse bit enables the watchdog
// (R2) Erased fuse reads one: watchdog on
// (R3) Watchdog overflow resets unless cleared first
// (R4) Fuse clear: software bit gates watchdog
// (R5) Overflow in Sleep wakes, sets both flags
// (R6) Four-bit level field sets detect threshold
// (R7) Reference-settled flag reported at bit 13
// (R8) Detector enabled only while enable bit set
// (R9) Power-save parameter selects Sleep or Idle
// (R10) Sleep stops clocks and oscillator
// (R11) Sleep exit on interrupt, reset, overflow
// (R12) Wake restarts previous clock source
// (R13) Crystal wake waits timer, lock, delays
// (R14) RC or external clock: base delay only
// (R15) Crystal kept in Sleep: base delay only
// (R16) Interrupt wake vectors and sets Sleep flag
// (R17) Resets wake; power-on clears Sleep flag
// (R18) Idle stops only the CPU clock
// (R19) Idle exit immediate, resumes next instruction
// (R20) Idle exit sets Idle flag except power-on
// (R21) Overflow in Idle wakes, sets both flags
// (R22) Configuration words 24 bits, low 16 used
// (R23) Watchdog counts on independent RC clock
package pswc_pkg;
   // Control register bit positions
   localparam int unsigned RC_IDLE_BIT = 2;
   localparam int unsigned RC_SLEEP_BIT = 3;
   localparam int unsigned RC_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
   localparam int unsigned RC_SWDT_BIT = 5;
   localparam int unsigned RC_LVL_LSB = 8;
   localparam int unsigned RC_LVL_MSB = 11;
   localparam int unsigned RC_LOWVOLT_DETECT_ENABLE_BIT = 12;
   localparam int unsigned RC_REF_STABLE_FLAG_BIT = 13;
   localparam logic [15:0] RC_WR_MASK = 16'h1f3c;
   localparam logic [15:0] RC_RESET = 16'h0000;
   // Configuration word addresses
   localparam logic [23:0] CFG_OSC_ADDR = 24'hf80000;
   localparam logic [23:0] CFG_WDT_ADDR = 24'hf80002;
   localparam logic [23:0] CFG_BOR_ADDR = 24'hf80004;
   localparam logic [23:0] CFG_GS_ADDR = 24'hf8000a;
   localparam int unsigned CFG_WDTEN_BIT = 15;
   localparam int unsigned CFG_FOS_LSB = 8;
   localparam logic [15:0] CFG_ERASED = 16'hffff;
   // Timing
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned BASE_DELAY_US = 10;
   localparam int unsigned BASE_DELAY_CYC = BASE_DELAY_US * CLK_MHZ;
   localparam int unsigned PWRT_US = 16000;
   localparam int unsigned PWRT_CYC = PWRT_US * CLK_MHZ;
   localparam int unsigned LOCK_US = 20;
   localparam int unsigned LOCK_CYC = LOCK_US * CLK_MHZ;
   // Oscillator source encodings
   localparam logic [2:0] OSC_LPXT = 3'h0;
   localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h2;
   localparam logic [2:0] OSC_PRI = 3'h3;
   localparam logic [2:0] OSC_FRC = 3'h1;
   // Power-save parameter
   localparam logic PS_SLEEP = 1'b0;
   localparam logic PS_IDLE = 1'b1;
   typedef enum logic [2:0] {
      PSWC_RUN, PSWC_SLEEP, PSWC_IDLE, PSWC_OSCWAIT, PSWC_DELAY
   } pswc_state_t;
endpackage

// file: src/pswc_top.sv
// Power-save, wake sequencing, watchdog and low-voltage control
`timescale 1ns/1ps
`default_nettype none
module pswc_top
   import pswc_pkg::*;
#(
   parameter int unsigned WDT_BITS = 16,
   parameter int unsigned BASE_CYC = BASE_DELAY_CYC,
   parameter int unsigned PWRT_CYCLES = PWRT_CYC,
   parameter int unsigned LOCK_CYCLES = LOCK_CYC
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Reset sources (pulses from reset logic)
   input wire logic por_i,
   input wire logic bor_i,
   input wire logic master_clear_pin_i,
   // CPU side
   input wire logic power_save_instr_exec_i,
   input wire logic power_save_instr_param_i,
   input wire logic wdt_clr_i,
   input wire logic irq_pending_i,
   input wire logic clk_switch_en_i,
   input wire logic [2:0] current_osc_sel_i,
   // Control register port
   input wire logic rc_we_i,
   input wire logic [15:0] rc_wdata_i,
   output logic [15:0] rc_rdata_o,
   // Configuration word table read
   input wire logic [23:0] cfg_addr_i,
   output logic [23:0] cfg_rdata_o,
   // Programmed fuse words
   input wire logic [15:0] fuse_osc_i,
   input wire logic [15:0] fuse_wdt_i,
   input wire logic [15:0] fuse_bor_i,
   input wire logic [15:0] fuse_gs_i,
   input wire logic fuse_valid_i,
   // Watchdog RC clock tick and analog status (asynchronous)
   input wire logic low_power_rc_osc_tick_i,
   input wire logic ref_settled_i,
   input wire logic ost_done_i,
   input wire logic pll_lock_i,
   input wire logic pll_used_i,
   // Clock and power outputs
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic osc_en_o,
   output logic low_power_rc_osc_en_o,
   output logic fail_safe_clock_monitor_active_o,
   output logic lvd_en_o,
   output logic [3:0] lvd_level_o,
   output logic [2:0] wake_osc_sel_o,
   output logic wdt_reset_o,
   output logic vector_irq_o,
   output logic resume_o
);
   pswc_state_t state_ff;
   logic [15:0] rc_ff;
   logic [WDT_BITS-1:0] wdt_cnt_ff;
   logic [31:0] dly_ff;
   logic [2:0] wake_osc_ff;
   logic [2:0] sleep_osc_ff;
   logic wake_irq_ff;
   logic wake_por_ff;
   logic wdt_reset_ff;
   logic vector_ff;
   logic resume_ff;
   logic [2:0] tick_sync_ff;
   logic [1:0] bg_sync_ff;
   logic [1:0] ost_sync_ff;
   logic [1:0] lock_sync_ff;
   logic wdt_en;
   logic wdt_ovf;
   logic any_rst;
   logic is_crystal;
   logic lp_kept;

   // Input synchronisers; the edge detector looks only past the 1st stage
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         tick_sync_ff <= 3'h0;
         bg_sync_ff <= 2'h0;
         ost_sync_ff <= 2'h0;
         lock_sync_ff <= 2'h0;
      end
      else
      begin
         tick_sync_ff <= {tick_sync_ff[1:0], low_power_rc_osc_tick_i};
         bg_sync_ff <= {bg_sync_ff[0], ref_settled_i};
         ost_sync_ff <= {ost_sync_ff[0], ost_done_i};
         lock_sync_ff <= {lock_sync_ff[0], pll_lock_i};
      end
   end

   // Fuse invalid means erased: all ones, so watchdog on by default
   logic [15:0] watchdog_config_word;
   assign watchdog_config_word = fuse_valid_i ? fuse_wdt_i : CFG_ERASED; // R2
   assign wdt_en = watchdog_config_word[CFG_WDTEN_BIT] | rc_ff[RC_SWDT_BIT]; // R1 R4
   assign wdt_ovf = wdt_en && (&wdt_cnt_ff) && tick_sync_ff[2]
                    && !tick_sync_ff[1];
   assign any_rst = por_i | bor_i | master_clear_pin_i;

   // Counts edges of the free-running RC tick, not the system clock
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         wdt_cnt_ff <= '0;
      else if (!wdt_en || wdt_clr_i || wdt_ovf || any_rst) // R3
         wdt_cnt_ff <= '0;
      else if (tick_sync_ff[2] && !tick_sync_ff[1])
         wdt_cnt_ff <= wdt_cnt_ff + 1'b1; // R23
   end

   // Overflow resets the device only in the Run state
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         wdt_reset_ff <= 1'b0;
      else
         wdt_reset_ff <= wdt_ovf && (state_ff == PSWC_RUN); // R3
   end

   assign is_crystal = (wake_osc_ff == OSC_PRI) || (wake_osc_ff == OSC_LPXT);
   // Low-power crystal kept alive through Sleep needs no restart wait
   assign lp_kept = (wake_osc_ff == OSC_LPXT) && (sleep_osc_ff == OSC_LPXT)
                    && !wake_por_ff;

   // Power-save state machine
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_ff <= PSWC_RUN;
         dly_ff <= '0;
         wake_osc_ff <= OSC_FRC;
         sleep_osc_ff <= OSC_FRC;
         wake_irq_ff <= 1'b0;
         wake_por_ff <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            PSWC_RUN:
               if (power_save_instr_exec_i)
               begin
                  sleep_osc_ff <= current_osc_sel_i;
                  state_ff <= (power_save_instr_param_i == PS_IDLE) ? PSWC_IDLE
                              : PSWC_SLEEP; // R9
               end
            PSWC_SLEEP:
               if (irq_pending_i || any_rst || wdt_ovf) // R11
               begin
                  wake_irq_ff <= irq_pending_i && !any_rst;
                  wake_por_ff <= por_i | bor_i;
                  // After power-on or brown-out the fuses pick the source
                  wake_osc_ff <= (por_i | bor_i || !clk_switch_en_i)
                     ? fuse_osc_i[CFG_FOS_LSB +: 3]
                     : current_osc_sel_i; // R12
                  state_ff <= PSWC_OSCWAIT;
               end
            PSWC_IDLE:
               if (irq_pending_i || any_rst || wdt_ovf)
               begin
                  wake_irq_ff <= irq_pending_i && !any_rst;
                  state_ff <= PSWC_RUN; // R19
               end
            PSWC_OSCWAIT:
               if (!is_crystal || lp_kept)
               begin
                  dly_ff <= BASE_CYC; // R14 R15
                  state_ff <= PSWC_DELAY;
               end
               else if (ost_sync_ff[1] && (!pll_used_i || lock_sync_ff[1]))
               begin
                  dly_ff <= BASE_CYC + PWRT_CYCLES
                            + (pll_used_i ? LOCK_CYCLES : 0); // R13
                  state_ff <= PSWC_DELAY;
               end
            PSWC_DELAY:
               if (dly_ff <= 32'h1)
                  state_ff <= PSWC_RUN;
               else
                  dly_ff <= dly_ff - 32'h1;
            default:
               state_ff <= PSWC_RUN;
         endcase
      end
   end

   // One-cycle resume and vector pulses when the CPU clock comes back
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         vector_ff <= 1'b0;
         resume_ff <= 1'b0;
      end
      else
      begin
         vector_ff <= 1'b0;
         resume_ff <= 1'b0;
         if ((state_ff == PSWC_IDLE && (irq_pending_i || wdt_ovf
              || any_rst)) || (state_ff == PSWC_DELAY && dly_ff <= 32'h1))
         begin
            vector_ff <= (state_ff == PSWC_IDLE) ? irq_pending_i
                         : wake_irq_ff; // R16
            resume_ff <= 1'b1; // R19
         end
      end
   end

   // Control register: software bits plus hardware status flags
   logic [15:0] nxt_rc;
   always_comb
   begin
      nxt_rc = rc_ff;
      if (rc_we_i)
         nxt_rc = (rc_ff & ~RC_WR_MASK) | (rc_wdata_i & RC_WR_MASK); // R6 R8
      // Hardware sets win over a software clear in the same cycle
      if (state_ff == PSWC_SLEEP && (irq_pending_i || any_rst || wdt_ovf))
         nxt_rc[RC_SLEEP_BIT] = 1'b1; // R16 R17
      if (state_ff == PSWC_IDLE && (irq_pending_i || any_rst || wdt_ovf))
         nxt_rc[RC_IDLE_BIT] = 1'b1; // R20
      if (wdt_ovf)
         nxt_rc[RC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1; // R5 R21
      if (por_i)
      begin
         nxt_rc[RC_SLEEP_BIT] = 1'b0; // R17
         nxt_rc[RC_IDLE_BIT] = 1'b0; // R20
      end
      nxt_rc[RC_REF_STABLE_FLAG_BIT] = bg_sync_ff[1]; // R7
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         rc_ff <= RC_RESET;
      else
         rc_ff <= nxt_rc;
   end

   // Configuration words: upper byte reads zero
   logic [23:0] nxt_cfg;
   logic [23:0] cfg_ff;
   always_comb
   begin
      nxt_cfg = 24'h000000;
      unique case (cfg_addr_i)
         CFG_OSC_ADDR: nxt_cfg = {8'h00, fuse_osc_i}; // R22
         CFG_WDT_ADDR: nxt_cfg = {8'h00, watchdog_config_word};
         CFG_BOR_ADDR: nxt_cfg = {8'h00, fuse_bor_i};
         CFG_GS_ADDR: nxt_cfg = {8'h00, fuse_gs_i};
         default: nxt_cfg = 24'h000000;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         cfg_ff <= 24'h000000;
      else
         cfg_ff <= nxt_cfg;
   end

   assign rc_rdata_o = rc_ff;
   assign cfg_rdata_o = cfg_ff;
   assign cpu_clk_en_o = (state_ff == PSWC_RUN); // R18
   assign periph_clk_en_o = (state_ff == PSWC_RUN)
                            || (state_ff == PSWC_IDLE); // R10 R18
   // Low-power crystal may run through Sleep; the RC runs if watchdog on or selected; others stop
   assign osc_en_o = (state_ff != PSWC_SLEEP)
                     || (sleep_osc_ff == OSC_LPXT); // R10
   assign low_power_rc_osc_en_o = wdt_en || (state_ff != PSWC_SLEEP)
                      || (sleep_osc_ff == OSC_LOW_POWER_RC_OSC); // R10
   assign fail_safe_clock_monitor_active_o = (state_ff != PSWC_SLEEP); // R10
   assign lvd_en_o = rc_ff[RC_LOWVOLT_DETECT_ENABLE_BIT]; // R8
   assign lvd_level_o = rc_ff[RC_LVL_MSB:RC_LVL_LSB]; // R6
   assign wake_osc_sel_o = wake_osc_ff; // R12
   assign wdt_reset_o = wdt_reset_ff;
   assign vector_irq_o = vector_ff;
   assign resume_o = resume_ff;
endmodule // pswc_top
`default_nettype wire

// file: test/pswc_chk.sv
// Concurrent checks on the power-save and wake control ports
`timescale 1ns/1ps
`default_nettype none
module pswc_chk
   import pswc_pkg::*;
(
   // Clock, reset and requests
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic por_i,
   input wire logic power_save_instr_exec_i,
   input wire logic power_save_instr_param_i,
   input wire logic irq_pending_i,
   // Observed outputs
   input wire logic [15:0] rc_rdata_o,
   input wire logic cpu_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic fail_safe_clock_monitor_active_o,
   input wire logic lvd_en_o,
   input wire logic [3:0] lvd_level_o,
   input wire logic wdt_reset_o,
   input wire logic vector_irq_o,
   input wire logic resume_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   lvd_enable_a: assert property ($changed(rc_rdata_o) |-> ##[0:1]
      lvd_en_o == rc_rdata_o[RC_LOWVOLT_DETECT_ENABLE_BIT]) else $error("detect enable off");
   lvd_level_a: assert property ($changed(rc_rdata_o) |-> ##[0:1]
      lvd_level_o == rc_rdata_o[RC_LVL_MSB:RC_LVL_LSB])
      else $error("detect level off");
   sleep_entry_a: assert property (power_save_instr_exec_i && !power_save_instr_param_i
      && cpu_clk_en_o |=> !cpu_clk_en_o && !periph_clk_en_o)
      else $error("sleep entry clocks wrong");
   idle_entry_a: assert property (power_save_instr_exec_i && power_save_instr_param_i
      && cpu_clk_en_o |=> !cpu_clk_en_o && periph_clk_en_o)
      else $error("idle entry clocks wrong");
   monitor_off_a: assert property ($fell(periph_clk_en_o)
      |-> !fail_safe_clock_monitor_active_o) else $error("clock monitor active in sleep");
   idle_wake_a: assert property (!cpu_clk_en_o && periph_clk_en_o
      && irq_pending_i |=> resume_o) else $error("idle wake late");
   sleep_wake_a: assert property (!periph_clk_en_o && irq_pending_i
      |-> ##[1:200] resume_o) else $error("sleep wake missing");
   sleep_flag_a: assert property (!periph_clk_en_o && irq_pending_i
      |-> ##[1:2] rc_rdata_o[RC_SLEEP_BIT]) else $error("sleep flag clear");
   por_flag_a: assert property (por_i |-> ##[1:2]
      !rc_rdata_o[RC_SLEEP_BIT] && !rc_rdata_o[RC_IDLE_BIT])
      else $error("power-on left flags set");
   wdt_pulse_a: assert property (wdt_reset_o |-> cpu_clk_en_o
      ##1 !wdt_reset_o) else $error("watchdog reset wrong");
   vector_a: assert property (vector_irq_o |-> resume_o)
      else $error("vector without resume");
endmodule // pswc_chk
bind pswc_top pswc_chk u_pswc_chk (.ref_clk_i, .rst_n_i, .por_i,
   .power_save_instr_exec_i, .power_save_instr_param_i, .irq_pending_i, .rc_rdata_o,
   .cpu_clk_en_o, .periph_clk_en_o, .fail_safe_clock_monitor_active_o, .lvd_en_o,
   .lvd_level_o, .wdt_reset_o, .vector_irq_o, .resume_o);
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the power-save and wake control block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import pswc_pkg::*;
();
   logic ref_clk_i, rst_n_i, por_i, bor_i, master_clear_pin_i, power_save_instr_exec_i;
   logic power_save_instr_param_i, wdt_clr_i, irq_pending_i, clk_switch_en_i;
   logic rc_we_i, fuse_valid_i, low_power_rc_osc_tick_i, ref_settled_i, ost_done_i;
   logic pll_lock_i, pll_used_i, tk_en;
   logic [2:0] current_osc_sel_i;
   logic [15:0] rc_wdata_i, fuse_osc_i, fuse_wdt_i, fuse_bor_i, fuse_gs_i;
   logic [23:0] cfg_addr_i, cfg_rdata_o;
   logic [15:0] rc_rdata_o;
   logic cpu_clk_en_o, periph_clk_en_o, osc_en_o, low_power_rc_osc_en_o, fail_safe_clock_monitor_active_o;
   logic lvd_en_o, wdt_reset_o, vector_irq_o, resume_o;
   logic [3:0] lvd_level_o;
   logic [2:0] wake_osc_sel_o;
   logic [11:0] n_res = 12'h0, n_wrst = 12'h0, er = 12'h0, ew = 12'h0;
   logic [7:0] n_vec = 8'h0;
   logic [25:0] exq[$];
   logic [25:0] nt;
   logic [15:0] fz[4];
   logic [23:0] ad[4];
   int err_total = 0, cmp_count = 0;
   pswc_top #(.WDT_BITS(3), .BASE_CYC(4), .PWRT_CYCLES(8), .LOCK_CYCLES(4))
      u_pswc_top (.*);
   always #2 ref_clk_i = ~ref_clk_i;
   // Watchdog RC ticks: one rising edge every two cycles
   always @(negedge ref_clk_i) if (tk_en) low_power_rc_osc_tick_i <= ~low_power_rc_osc_tick_i;
   task automatic tk(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic expect_v(input logic [1:0] s, input logic [23:0] v);
      exq.push_back({s, v});
      tk(1);
   endtask
   task automatic wr(input logic [15:0] d);
      rc_wdata_i = d;
      rc_we_i = 1'h1;
      tk(1);
      rc_we_i = 1'h0;
   endtask
   task automatic ps(input logic p);
      power_save_instr_param_i = p;
      power_save_instr_exec_i = 1'h1;
      tk(1);
      power_save_instr_exec_i = 1'h0;
   endtask
   // A missing wake shows up as a count mismatch, never as a hang
   task automatic wait_res(input int lim);
      repeat (lim) if (n_res == er) tk(1);
      er++;
      expect_v(2'h3, {ew, er});
   endtask
   task automatic conclude;
      $display("compared %0d, mismatched %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      if (resume_o === 1'h1) n_res++;
      if (wdt_reset_o === 1'h1) n_wrst++;
      if (vector_irq_o === 1'h1) n_vec++;
      while (exq.size() > 0)
      begin
         nt = exq.pop_front();
         case (nt[25:24])
            2'h0: check({8'h0, rc_rdata_o}, nt[23:0]);
            2'h1: check(cfg_rdata_o, nt[23:0]);
            2'h2: check({n_vec, 8'h0, wake_osc_sel_o, cpu_clk_en_o,
               periph_clk_en_o, osc_en_o, fail_safe_clock_monitor_active_o, low_power_rc_osc_en_o},
               nt[23:0]);
            default: check({n_wrst, n_res}, nt[23:0]);
         endcase
      end
   end
   initial
   begin
      #40000;
      err_total++;
      conclude;
   end
   initial
   begin
      {ref_clk_i, rst_n_i, por_i, bor_i, master_clear_pin_i, power_save_instr_exec_i, power_save_instr_param_i,
         wdt_clr_i, irq_pending_i, rc_we_i, low_power_rc_osc_tick_i, ref_settled_i,
         ost_done_i, pll_lock_i, pll_used_i, tk_en, rc_wdata_i, cfg_addr_i} = '0;
      {clk_switch_en_i, fuse_valid_i, current_osc_sel_i} = {2'h3, OSC_FRC};
      ad = '{CFG_OSC_ADDR, CFG_WDT_ADDR, CFG_BOR_ADDR, CFG_GS_ADDR};
      void'($urandom(32'h69e10efc));
      foreach (fz[i]) fz[i] = 16'($urandom);
      fz[1][CFG_WDTEN_BIT] = 1'h1;
      {fuse_osc_i, fuse_wdt_i, fuse_bor_i, fuse_gs_i} = {fz[0], fz[1], fz[2], fz[3]};
      tk(2);
      rst_n_i = 1'h1;
      tk(3);
      expect_v(2'h2, {8'h0, 8'h0, 3'h1, 5'h1f});
      expect_v(2'h0, 24'h0);
      rc_wdata_i = 16'($urandom);
      wr(rc_wdata_i);
      expect_v(2'h0, {8'h0, rc_wdata_i & RC_WR_MASK});
      ref_settled_i = 1'h1;
      tk(4);
      expect_v(2'h0, {8'h0, rc_wdata_i & RC_WR_MASK | 16'h2000});
      wr(16'h0);
      $display("register test done");
      for (int i = 0; i < 5; i++)
      begin
         cfg_addr_i = (i < 4) ? ad[i] : 24'hf80006;
         tk(1);
         expect_v(2'h1, (i < 4) ? {8'h0, fz[i]} : 24'h0);
      end
      fuse_valid_i = 1'h0;
      cfg_addr_i = CFG_WDT_ADDR;
      tk(1);
      expect_v(2'h1, 24'h00ffff);
      fuse_valid_i = 1'h1;
      $display("configuration test done");
      ps(PS_SLEEP);
      expect_v(2'h2, {8'h0, 8'h0, 3'h1, 5'h01});
      irq_pending_i = 1'h1;
      wait_res(20);
      irq_pending_i = 1'h0;
      expect_v(2'h0, 24'h2008);
      {current_osc_sel_i, pll_used_i} = {OSC_PRI, 1'h1};
      ps(PS_SLEEP);
      irq_pending_i = 1'h1;
      tk(3);
      irq_pending_i = 1'h0;
      tk(40);
      expect_v(2'h3, {ew, er});
      {ost_done_i, pll_lock_i} = 2'h3;
      tk(12);
      expect_v(2'h3, {ew, er});
      wait_res(40);
      expect_v(2'h2, {8'h2, 8'h0, OSC_PRI, 5'h1f});
      {current_osc_sel_i, pll_used_i, ost_done_i} = {OSC_LPXT, 2'h0};
      ps(PS_SLEEP);
      irq_pending_i = 1'h1;
      wait_res(20);
      irq_pending_i = 1'h0;
      $display("sleep test done");
      wr(16'h0);
      ps(PS_IDLE);
      irq_pending_i = 1'h1;
      wait_res(3);
      irq_pending_i = 1'h0;
      expect_v(2'h0, 24'h2004);
      wr(16'h0);
      $display("idle test done");
      tk_en = 1'h1;
      repeat (8)
      begin
         wdt_clr_i = 1'h1;
         tk(1);
         wdt_clr_i = 1'h0;
         tk(7);
      end
      expect_v(2'h3, {ew, er});
      repeat (40) if (n_wrst == ew) tk(1);
      ew++;
      ps(PS_SLEEP);
      wait_res(40);
      expect_v(2'h0, 24'h2018);
      ps(PS_IDLE);
      wait_res(30);
      tk_en = 1'h0;
      expect_v(2'h0, 24'h201c);
      $display("watchdog test done");
      {ost_done_i, pll_lock_i} = 2'h3;
      wr(16'h0);
      ps(PS_SLEEP);
      por_i = 1'h1;
      tk(1);
      por_i = 1'h0;
      repeat (60) if (cpu_clk_en_o !== 1'h1) tk(1);
      expect_v(2'h0, 24'h2000);
      expect_v(2'h2, {8'h4, 8'h0, fz[0][10:8], 5'h1f});
      $display("power-on test done");
      conclude;
   end
endmodule // testbench
`default_nettype wire
